// File: hdl/scmc_pkg.sv
// Purpose: Shared types and constants of the star coupler mode controller.
// Assumes: A 20 MHz system clock.
// Notes:   Timeout figures are plain defaults; the top module turns them into parameters.
package scmc_pkg;

  // Operating modes, one-hot.
  typedef enum logic [5:0] {
    M_IDLE  = 6'h01,
    M_TX    = 6'h02,
    M_RX    = 6'h04,
    M_LOCK  = 6'h08,
    M_STBY  = 6'h10,
    M_SLEEP = 6'h20
  } scmc_mode_t;

  localparam int CLK_MHZ = 20;
  localparam int CW      = 24;
  localparam int FIFO_W  = 1;
  localparam int FIFO_D  = 8;

  // Timeouts in ns, and the cycle counts derived from them (rounded up).
  localparam int LOCK_IDLE_NS   = 10000;
  localparam int IDLE_SLEEP_NS  = 640000;
  localparam int TX_LOCK_NS     = 2000000;
  localparam int RX_LOCK_NS     = 2000000;
  localparam int UV_STBY_NS     = 500000;
  localparam int UV_DET_NS      = 100000;
  localparam int LOCK_SLEEP_NS  = 640000;
  localparam int LOCK_IDLE_CYC  = (LOCK_IDLE_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_SLEEP_CYC = (IDLE_SLEEP_NS * CLK_MHZ + 999) / 1000;
  localparam int TX_LOCK_CYC    = (TX_LOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int RX_LOCK_CYC    = (RX_LOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int UV_STBY_CYC    = (UV_STBY_NS * CLK_MHZ + 999) / 1000;
  localparam int UV_DET_CYC     = (UV_DET_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_SLEEP_CYC = (LOCK_SLEEP_NS * CLK_MHZ + 999) / 1000;

  // Asynchronous pin and flag inputs, synchronised as one group.
  typedef struct packed {
    logic bus_act;
    logic bus_data;
    logic transmit_request_n;
    logic txd;
    logic guardian_enable;
    logic branch_link_a;
    logic branch_link_b;
    logic core_uv;
    logic io_ok;
    logic buf_ok;
    logic wake_event;
    logic error_flag;
  } scmc_pins_t;

  typedef struct packed {
    scmc_pins_t      s1;
    scmc_pins_t      s2;
    scmc_mode_t      mode;
    logic            org_local;
    logic            wake;
    logic            power_on_flag;
    logic            star;
    logic            uv_prev;
    logic [CW-1:0]   c_li;
    logic [CW-1:0]   c_is;
    logic [CW-1:0]   c_tl;
    logic [CW-1:0]   c_rl;
    logic [CW-1:0]   c_us;
    logic [CW-1:0]   c_ud;
    logic [CW-1:0]   c_ls;
    logic            tx_en;
    logic            btxd;
    logic            link_o;
    logic            link_oe_n;
    logic            rxd;
    logic            rx_act_n;
    logic            err_n;
    logic            inh_oe_n;
    logic [1:0]      link_own;
  } scmc_state_t;

  // Both pin stages reset to undervoltage, so the power-on flag waits for real pin samples.
  localparam scmc_state_t STATE_RST = '{s1: '{core_uv: 1'b1, default: '0},
                                        s2: '{core_uv: 1'b1, default: '0},
                                        mode: M_STBY, power_on_flag: 1'b1, btxd: 1'b1, link_o: 1'b1,
                                        link_oe_n: 1'b1, rxd: 1'b1, rx_act_n: 1'b1,
                                        err_n: 1'b1, default: '0};

endpackage

// File: hdl/scmc_top.sv
// Purpose: Autonomous mode controller of a transceiver strapped as an active star coupler.
// Assumes: Pins arrive asynchronously; bus_tx_ready_in comes from logic on clk_in.
// Notes:   Inhibit outputs are open pins: oe_n high means floating.
// Notes on behaviour
// R1: Star strap ignores mode pins; self-controlled modes.
// R2: Error pin low while error flag set and supplies good.
// R3: Normal modes: receive pins follow the bus.
// R4: Low-power modes: receive pins show wake flag when supplies good.
// R5: Inhibits high, floating only in sleep.
// R6: Local transmit needs guardian enable high.
// R7: Unused transmit request is tied inactive.
// R8: Link lines driven in receive or local transmit.
// R9: Transmit/receive return idle when all quiet.
// R10: Locked returns idle after quiet timeout.
// R11: Standby to idle on wake or no undervoltage.
// R12: Sleep to idle when wake flag set.
// R13: Idle to transmit, remembering the starting source.
// R14: Transmit enables driver, routes chosen source.
// R15: Idle to receive; bus data onto links.
// R16: Receive mode keeps transmitter disabled.
// R17: Standby on long undervoltage with wake, or power-on; the shorter default P_UV_DET sends undervoltage to sleep first.
// R18: Sleep on undervoltage, idle or locked timeouts.
// R19: Locked after transmit or receive activity timeout.
// R20: Locked mode keeps transmitter disabled.
// R21: Power-on clear latches star or node configuration.
// R22: Link activity sets wake; low power clears.
// R23: Power-on flag clears when undervoltage ends.
// R24: Registered mode; restartable timeout counters.
`timescale 1ns/10ps

module scmc_fifo #(
  parameter int W = 1,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  // Filling side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // Draining side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } scmc_fifo_st_t;

  scmc_fifo_st_t f_r;
  scmc_fifo_st_t f_nxt;
  logic          push;
  logic          pop;

  assign in_ready_out  = f_r.cnt != (AW+1)'(D);
  assign out_valid_out = f_r.cnt != '0;
  assign out_data_out  = f_r.mem[f_r.rp];

  always_comb begin
    f_nxt = f_r;
    push  = in_valid_in && in_ready_out;
    pop   = out_valid_out && out_ready_in;
    if (push) begin
      f_nxt.mem[f_r.wp] = in_data_in;
      f_nxt.wp          = (f_r.wp == AW'(D - 1)) ? '0 : f_r.wp + 1'b1;
    end
    if (pop) begin
      f_nxt.rp = (f_r.rp == AW'(D - 1)) ? '0 : f_r.rp + 1'b1;
    end
    if (push && !pop) begin
      f_nxt.cnt = f_r.cnt + 1'b1;
    end else if (pop && !push) begin
      f_nxt.cnt = f_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end
endmodule // scmc_fifo

module scmc_top #(
  parameter int unsigned P_LOCK_IDLE  = scmc_pkg::LOCK_IDLE_CYC,
  parameter int unsigned P_IDLE_SLEEP = scmc_pkg::IDLE_SLEEP_CYC,
  parameter int unsigned P_TX_LOCK    = scmc_pkg::TX_LOCK_CYC,
  parameter int unsigned P_RX_LOCK    = scmc_pkg::RX_LOCK_CYC,
  parameter int unsigned P_UV_STBY    = scmc_pkg::UV_STBY_CYC,
  parameter int unsigned P_UV_DET     = scmc_pkg::UV_DET_CYC,
  parameter int unsigned P_LOCK_SLEEP = scmc_pkg::LOCK_SLEEP_CYC
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  // Pins and flags from outside the clock domain
  input  wire scmc_pkg::scmc_pins_t pins_in,
  // Bus transmitter
  input  wire logic                 bus_tx_ready_in,
  output logic                      bus_tx_en_out,
  output logic                      bus_txd_out,
  output logic                      tx_path_ready_out,
  // Inter-branch link
  output logic                      branch_link_a_out,
  output logic                      branch_link_b_out,
  output logic                      branch_link_oe_n_out,
  // Controller side indications
  output logic                      rx_data_out,
  output logic                      receive_activity_n_out,
  output logic                      error_indicate_n_out,
  // Inhibit switches
  output logic                      inhibit_out_a_out,
  output logic                      inhibit_out_b_out,
  output logic                      inhibit_oe_n_out,
  // Status
  output scmc_pkg::scmc_mode_t      mode_out,
  output logic                      star_cfg_out
);
  import scmc_pkg::*;

  scmc_state_t s_r;
  scmc_state_t s_nxt;
  scmc_pins_t  p;
  logic        tx_raw;
  logic        transmit_request_n_act;
  logic        lnk_act;
  logic        quiet;
  logic        normal;
  logic        f_in_ready;
  logic        f_in_valid;
  logic        f_in_data;
  logic        f_out_valid;
  logic        f_out_data;

  // Counts while en holds, saturates, and restarts as soon as en lapses.
  function automatic logic [CW-1:0] tick(input logic [CW-1:0] c, input logic en);
    tick = !en ? '0 : (&c ? c : c + 1'b1);
  endfunction

  function automatic logic reached(input logic [CW-1:0] c, input int unsigned lim);
    reached = c >= lim[CW-1:0];
  endfunction

  function automatic logic low_pwr(input scmc_mode_t m);
    low_pwr = (m == M_STBY) || (m == M_SLEEP);
  endfunction

  // Bits reach the bus through a small buffer so the transmitter can stall briefly.
  scmc_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (f_in_valid),
    .in_ready_out  (f_in_ready),
    .in_data_in    (f_in_data),
    .out_valid_out (f_out_valid),
    .out_ready_in  (bus_tx_ready_in),
    .out_data_out  (f_out_data)
  );

  assign f_in_valid = s_r.mode == M_TX;
  assign f_in_data  = s_r.org_local ? s_r.s2.txd : s_r.s2.branch_link_a; // R14

  always_comb begin
    s_nxt    = s_r;
    p        = s_r.s2;
    s_nxt.s1 = pins_in;
    s_nxt.s2 = s_r.s1;
    // A tied-low request pin would be permanent activity; the board ties it inactive.
    tx_raw   = !p.transmit_request_n; // R7
    transmit_request_n_act = tx_raw && p.guardian_enable; // R6
    // Our own link drive echoes through the synchroniser for two cycles after release; it is not activity.
    s_nxt.link_own = {s_r.link_own[0], !s_r.link_oe_n};
    lnk_act  = s_r.link_oe_n && !(|s_r.link_own) && (!p.branch_link_a || !p.branch_link_b); // R9 R13
    quiet    = !tx_raw && !lnk_act && !p.bus_act;

    s_nxt.c_ud = tick(s_r.c_ud, p.core_uv); // R24
    s_nxt.c_us = tick(s_r.c_us, p.core_uv && s_r.wake && !low_pwr(s_r.mode) && s_r.mode != M_LOCK);
    s_nxt.c_is = tick(s_r.c_is, s_r.mode == M_IDLE && quiet);
    s_nxt.c_tl = tick(s_r.c_tl, s_r.mode == M_TX && tx_raw);
    s_nxt.c_rl = tick(s_r.c_rl, s_r.mode == M_RX && p.bus_act);
    s_nxt.c_li = tick(s_r.c_li, s_r.mode == M_LOCK && !p.bus_act && !tx_raw);
    s_nxt.c_ls = tick(s_r.c_ls, s_r.mode == M_LOCK);

    // Configuration is caught on the clearing of the power-on flag.
    s_nxt.uv_prev = p.core_uv;
    if (s_r.power_on_flag && !p.core_uv) begin
      s_nxt.power_on_flag = 1'b0; // R23
      s_nxt.star = p.branch_link_a || p.branch_link_b; // R21
    end

    // Mode pins are not even wired in: a star branch picks its own mode.
    case (s_r.mode) // R1
      M_IDLE: begin
        if (transmit_request_n_act) begin
          s_nxt.mode      = M_TX; // R13
          s_nxt.org_local = 1'b1;
        end else if (lnk_act) begin
          s_nxt.mode      = M_TX; // R13
          s_nxt.org_local = 1'b0;
        end else if (p.bus_act) begin
          s_nxt.mode = M_RX; // R15
        end else if (reached(s_r.c_is, P_IDLE_SLEEP)) begin
          s_nxt.mode = M_SLEEP; // R18
        end
      end
      M_TX, M_RX: begin
        if (quiet) begin
          s_nxt.mode = M_IDLE; // R9
        end else if (s_r.mode == M_TX && reached(s_r.c_tl, P_TX_LOCK)) begin
          s_nxt.mode = M_LOCK; // R19
        end else if (s_r.mode == M_RX && reached(s_r.c_rl, P_RX_LOCK)) begin
          s_nxt.mode = M_LOCK; // R19
        end
      end
      M_LOCK: begin
        if (reached(s_r.c_li, P_LOCK_IDLE)) begin
          s_nxt.mode = M_IDLE; // R10
        end else if (reached(s_r.c_ls, P_LOCK_SLEEP)) begin
          s_nxt.mode = M_SLEEP; // R18
        end
      end
      M_STBY: begin
        // A node-strapped part never leaves standby here; this block only serves star use.
        if (s_r.star && !s_r.power_on_flag && (s_r.wake || !p.core_uv)) begin
          s_nxt.mode = M_IDLE; // R11
        end
      end
      M_SLEEP: begin
        if (s_r.star && s_r.wake) begin
          s_nxt.mode = M_IDLE; // R12
        end
      end
      default: begin
        s_nxt.mode = M_STBY;
      end
    endcase
    if (reached(s_r.c_us, P_UV_STBY)) begin
      s_nxt.mode = M_STBY; // R17
    end
    if (reached(s_r.c_ud, P_UV_DET)) begin
      s_nxt.mode = M_SLEEP; // R18
    end
    // Power-on outranks undervoltage so the strap can still be taken.
    if (s_r.power_on_flag) begin
      s_nxt.mode = M_STBY; // R17
    end

    // Set wins over clear, so link activity in the clearing cycle is kept.
    if ((low_pwr(s_nxt.mode) && !low_pwr(s_r.mode)) || (s_r.uv_prev && !p.core_uv)) begin
      s_nxt.wake = 1'b0; // R22
    end
    if ((s_r.star && lnk_act) || p.wake_event) begin
      s_nxt.wake = 1'b1; // R22
    end

    // Outputs follow the next mode so they line up with the mode register.
    normal          = !low_pwr(s_nxt.mode);
    s_nxt.tx_en     = s_nxt.mode == M_TX && (!s_nxt.org_local || p.guardian_enable); // R14 R16 R20
    s_nxt.link_oe_n = !(s_nxt.mode == M_RX || (s_nxt.mode == M_TX && s_nxt.org_local)); // R8
    s_nxt.link_o    = (s_nxt.mode == M_RX) ? p.bus_data : p.txd; // R15
    if (normal) begin
      s_nxt.rxd      = p.bus_data; // R3
      s_nxt.rx_act_n = !p.bus_act; // R3
    end else if (p.io_ok && p.buf_ok) begin
      s_nxt.rxd      = !s_nxt.wake; // R4
      s_nxt.rx_act_n = !s_nxt.wake; // R4
    end else begin
      s_nxt.rxd      = 1'b1;
      s_nxt.rx_act_n = 1'b1;
    end
    // Without supplies the pin stays passive high rather than claim an error.
    s_nxt.err_n    = !(p.io_ok && p.buf_ok && p.error_flag); // R2
    s_nxt.inh_oe_n = s_nxt.mode == M_SLEEP; // R5
    if (f_out_valid && bus_tx_ready_in) begin
      s_nxt.btxd = f_out_data;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt; // R24
    end
  end

  assign bus_tx_en_out          = s_r.tx_en;
  assign bus_txd_out            = s_r.btxd;
  assign tx_path_ready_out      = f_in_ready;
  assign branch_link_a_out      = s_r.link_o;
  assign branch_link_b_out      = s_r.link_o;
  assign branch_link_oe_n_out   = s_r.link_oe_n;
  assign rx_data_out            = s_r.rxd;
  assign receive_activity_n_out = s_r.rx_act_n;
  assign error_indicate_n_out   = s_r.err_n;
  assign inhibit_out_a_out      = 1'b1;
  assign inhibit_out_b_out      = 1'b1;
  assign inhibit_oe_n_out       = s_r.inh_oe_n;
  assign mode_out               = s_r.mode;
  assign star_cfg_out           = s_r.star;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  chk_rx_tx_off: assert property (s_r.mode == M_RX |-> !bus_tx_en_out) // R16
    else $error("transmitter enabled in receive mode");
  chk_lock_silent: assert property (s_r.mode == M_LOCK |-> !bus_tx_en_out) // R20
    else $error("transmitter enabled in locked mode");
  chk_inhibit_float: assert property (inhibit_oe_n_out == (s_r.mode == M_SLEEP)) // R5
    else $error("inhibit drive wrong for mode");
  chk_guardian_gate: assert property ((s_nxt.mode == M_TX && s_nxt.org_local && !p.guardian_enable)
                                      |=> !bus_tx_en_out) // R6
    else $error("local transmit without guardian enable");
  chk_link_dir: assert property (branch_link_oe_n_out == !(s_r.mode == M_RX || (s_r.mode == M_TX && s_r.org_local))) // R8
    else $error("link direction wrong");
  chk_wake_pins: assert property ((low_pwr(s_r.mode) && $past(p.io_ok && p.buf_ok))
                                  |-> rx_data_out == !s_r.wake && receive_activity_n_out == !s_r.wake) // R4
    else $error("receive pins do not show wake flag");
  chk_bus_follow: assert property (!low_pwr(s_r.mode) |-> rx_data_out == $past(p.bus_data)) // R3
    else $error("receive data does not follow bus");
  chk_lock_entry: assert property ($rose(s_r.mode == M_LOCK) |-> $past(s_r.mode == M_TX || s_r.mode == M_RX)) // R19
    else $error("locked entered from wrong mode");
  chk_sleep_wake: assert property ((s_r.mode == M_SLEEP && s_r.star && s_r.wake && !s_r.power_on_flag
                                    && !reached(s_r.c_ud, P_UV_DET) && !reached(s_r.c_us, P_UV_STBY))
                                   |=> s_r.mode == M_IDLE) // R12
    else $error("sleep did not leave on wake");
  chk_power_on_flag_stby: assert property (s_r.power_on_flag |=> s_r.mode == M_STBY) // R17
    else $error("power-on flag did not force standby");
  chk_err_pin: assert property (error_indicate_n_out == !$past(p.io_ok && p.buf_ok && p.error_flag)) // R2
    else $error("error pin mismatch");
  chk_idle_quiet: assert property ((s_r.mode == M_TX && quiet && !s_r.power_on_flag && !reached(s_r.c_ud, P_UV_DET)
                                    && !reached(s_r.c_us, P_UV_STBY)) |=> s_r.mode == M_IDLE) // R9
    else $error("transmit did not return to idle");

  cov_tx_local: cover property (s_r.mode == M_TX && s_r.org_local);
  cov_tx_link: cover property (s_r.mode == M_TX && !s_r.org_local);
  cov_locked: cover property (s_r.mode == M_LOCK ##1 s_r.mode == M_IDLE);
  cov_sleep_wake: cover property (s_r.mode == M_SLEEP ##1 s_r.mode == M_IDLE);
endmodule // scmc_top

// File: verification/scmc_partner.sv
// Purpose: Far side of the star coupler: bus receiver, other branches and the bus transmitter.
// Assumes: Link lines have pull-ups; the bus reads DATA_1 when idle.
// Notes:   The transmitter takes bits only while drain_in is set, promptly or on every fourth cycle.
`timescale 1ns/10ps
module scmc_partner (
  // Clock
  input  wire logic clk_in,
  // Scenario controls
  input  wire logic link_act_in,
  input  wire logic bus_busy_in,
  input  wire logic bus_bit_in,
  input  wire logic drain_in,
  input  wire logic slow_in,
  // Block drive of the link lines
  input  wire logic dut_link_a_in,
  input  wire logic dut_link_b_in,
  input  wire logic dut_link_oe_n_in,
  // Resolved lines seen by the block
  output logic      link_a_out,
  output logic      link_b_out,
  output logic      bus_act_out,
  output logic      bus_data_out,
  output logic      tx_ready_out
);
  logic [1:0] div_r = 2'h0;

  always @(posedge clk_in) begin
    div_r <= div_r + 2'h1;
  end

  // A released link shows the other branches: low while link_act_in is set, else high from its pull-up, so it never keeps the last driven level.
  assign link_a_out   = !dut_link_oe_n_in ? dut_link_a_in : !link_act_in;
  assign link_b_out   = !dut_link_oe_n_in ? dut_link_b_in : !link_act_in;
  assign bus_act_out  = bus_busy_in;
  assign bus_data_out = bus_busy_in ? bus_bit_in : 1'b1;
  assign tx_ready_out = drain_in & (!slow_in | (div_r == 2'h0));
endmodule // scmc_partner

// File: verification/tb.sv
// Purpose: Self-checking bench for the star coupler mode controller.
// Assumes: Shortened timeouts; timeout delays derive from the local parameters, pin-to-mode delays use fixed windows.
// Notes:   Mode changes are compared against a queue of expected modes.
`timescale 1ns/10ps
module tb;
  import scmc_pkg::*;
  localparam int PLI = 6;
  localparam int PIS = 60;
  localparam int PTL = 40;
  localparam int PRL = 20;
  localparam int PUD = 8;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  scmc_pins_t  drv;
  scmc_pins_t  pins;
  logic        link_act = 1'b0;
  logic        bus_busy = 1'b0;
  logic        bus_bit = 1'b1;
  logic        drain = 1'b0;
  logic        slow = 1'b0;
  logic        la, lb, ba, bd, txr, tx_en, btxd, tx_rdy, lao, lbo, loe_n;
  logic        rxd, rxa_n, err_n, inh_a, inh_b, inh_oe_n, star;
  scmc_mode_t  mode;
  scmc_mode_t  last_mode = M_STBY;
  scmc_mode_t  exp_q[$];
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  longint      mark_t = 0;
  integer      seed = 32'h9FEF50D5;
  logic [31:0] v;

  always #25 clk_in = ~clk_in;

  always_comb begin
    pins = drv;
    pins.bus_act = ba;
    pins.bus_data = bd;
    pins.branch_link_a = la;
    pins.branch_link_b = lb;
  end

  scmc_top #(.P_LOCK_IDLE(PLI), .P_IDLE_SLEEP(PIS), .P_TX_LOCK(PTL), .P_RX_LOCK(PRL), .P_UV_STBY(30),
             .P_UV_DET(PUD), .P_LOCK_SLEEP(200)) uut (
    .clk_in(clk_in), .nrst_in(nrst_in), .pins_in(pins), .bus_tx_ready_in(txr),
    .bus_tx_en_out(tx_en), .bus_txd_out(btxd), .tx_path_ready_out(tx_rdy),
    .branch_link_a_out(lao), .branch_link_b_out(lbo), .branch_link_oe_n_out(loe_n),
    .rx_data_out(rxd), .receive_activity_n_out(rxa_n), .error_indicate_n_out(err_n),
    .inhibit_out_a_out(inh_a), .inhibit_out_b_out(inh_b), .inhibit_oe_n_out(inh_oe_n),
    .mode_out(mode), .star_cfg_out(star));

  scmc_partner far (
    .clk_in(clk_in), .link_act_in(link_act), .bus_busy_in(bus_busy), .bus_bit_in(bus_bit),
    .drain_in(drain), .slow_in(slow), .dut_link_a_in(lao), .dut_link_b_in(lbo),
    .dut_link_oe_n_in(loe_n), .link_a_out(la), .link_b_out(lb), .bus_act_out(ba),
    .bus_data_out(bd), .tx_ready_out(txr));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic edge_mark();
    @(posedge clk_in);
    mark_t = $time;
  endtask

  // Notes the mode, waits for it and times the change from the last mark.
  task automatic expect_mode(input scmc_mode_t m, input int lo, input int hi);
    longint el;
    exp_q.push_back(m);
    for (int n = 0; n <= hi + 2 && mode !== m; n++) @(negedge clk_in);
    el = ($time - mark_t) / 50;
    check("mode delay", {7'h00, el >= lo && el <= hi}, 8'h01);
    mark_t = $time;
  endtask

  always @(negedge clk_in) begin
    if (mode !== last_mode) begin
      if (exp_q.size() == 0) check("mode unexpected", {2'h0, mode}, {2'h0, last_mode});
      else check("mode", {2'h0, mode}, {2'h0, exp_q.pop_front()});
      last_mode = mode;
    end
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    // Bus idle, request idle, guardian on, links high, supplies good, no wake or error.
    drv = 12'h7EC;
    cycles(10);
    check("reset outputs", {star, tx_en, btxd, loe_n, rxd, rxa_n, err_n, inh_oe_n}, 8'h3E);
    check("inhibit", {inh_a, inh_b, inh_oe_n}, 8'h06);
    edge_mark();
    nrst_in <= 1'b1;
    expect_mode(M_IDLE, 3, 6);
    check("star cfg", star, 8'h01);
    repeat (4) begin
      v = $random(seed);
      @(posedge clk_in);
      drv.error_flag <= v[0];
      cycles(4);
      check("error pin", err_n, !v[0]);
    end
    v = $random(seed);
    @(posedge clk_in);
    drv.guardian_enable <= 1'b0;
    drv.transmit_request_n <= 1'b0;
    drv.txd <= v[0];
    cycles(8);
    check("refused", {mode, tx_en}, {M_IDLE, 1'b0});
    edge_mark();
    drv.guardian_enable <= 1'b1;
    expect_mode(M_TX, 3, 5);
    cycles(2);
    check("local tx", {tx_en, loe_n, lao, lbo}, {2'b10, v[0], v[0]});
    @(posedge clk_in);
    drv.guardian_enable <= 1'b0;
    cycles(4);
    check("guardian drop", {mode, tx_en}, {M_TX, 1'b0});
    @(posedge clk_in);
    drv.guardian_enable <= 1'b1;
    cycles(10);
    check("fifo full", tx_rdy, 8'h00);
    @(posedge clk_in);
    drain <= 1'b1;
    cycles(10);
    check("bus data", btxd, v[0]);
    @(posedge clk_in);
    drain <= 1'b0;
    expect_mode(M_LOCK, PTL, PTL + 4);
    check("locked", {tx_en, loe_n}, 8'h01);
    edge_mark();
    drv.transmit_request_n <= 1'b1;
    expect_mode(M_IDLE, PLI, PLI + 6);
    @(posedge clk_in);
    drain <= 1'b1;
    cycles(12);
    check("fifo drained", tx_rdy, 8'h01);
    edge_mark();
    link_act <= 1'b1;
    slow <= 1'b1;
    expect_mode(M_TX, 3, 5);
    check("link tx", {tx_en, loe_n}, 8'h03);
    cycles(24);
    check("link to bus", btxd, 8'h00);
    edge_mark();
    link_act <= 1'b0;
    expect_mode(M_IDLE, 3, 5);
    v = $random(seed);
    edge_mark();
    bus_bit <= v[0];
    bus_busy <= 1'b1;
    expect_mode(M_RX, 3, 5);
    cycles(2);
    check("receive", {tx_en, loe_n, lao, lbo, rxd, rxa_n}, {2'b00, v[0], v[0], v[0], 1'b0});
    edge_mark();
    bus_busy <= 1'b0;
    expect_mode(M_IDLE, 3, 5);
    edge_mark();
    bus_busy <= 1'b1;
    expect_mode(M_RX, 3, 5);
    expect_mode(M_LOCK, PRL, PRL + 4);
    check("rx locked", {tx_en, loe_n}, 8'h01);
    edge_mark();
    bus_busy <= 1'b0;
    expect_mode(M_IDLE, PLI, PLI + 6);
    cycles(1);
    check("bus idle", {rxd, rxa_n}, 8'h03);
    expect_mode(M_SLEEP, PIS, PIS + 4);
    check("sleep pins", {inh_oe_n, rxd, rxa_n}, 8'h07);
    edge_mark();
    drv.wake_event <= 1'b1;
    expect_mode(M_IDLE, 3, 5);
    edge_mark();
    drv.wake_event <= 1'b0;
    drv.core_uv <= 1'b1;
    expect_mode(M_SLEEP, PUD, PUD + 6);
    @(posedge clk_in);
    drv.core_uv <= 1'b0;
    cycles(8);
    check("wake cleared", {rxd, rxa_n}, 8'h03);
    edge_mark();
    link_act <= 1'b1;
    expect_mode(M_IDLE, 3, 6);
    expect_mode(M_TX, 1, 4);
    edge_mark();
    link_act <= 1'b0;
    expect_mode(M_IDLE, 3, 5);
    @(posedge clk_in);
    exp_q.push_back(M_STBY);
    nrst_in <= 1'b0;
    link_act <= 1'b1;
    cycles(3);
    @(posedge clk_in);
    nrst_in <= 1'b1;
    cycles(10);
    check("node cfg", {star, rxd, rxa_n}, 8'h03);
    @(posedge clk_in);
    drv.wake_event <= 1'b1;
    cycles(5);
    check("wake shown", {mode, rxd, rxa_n}, {M_STBY, 2'b00});
    @(posedge clk_in);
    drv.buf_ok <= 1'b0;
    cycles(5);
    check("supply out", {rxd, rxa_n}, 8'h03);
    final_report();
  end
endmodule // tb
